// ===== rtl/nfs_pkg.sv
// Package for the network fault supervisor: register map, field layout,
// reset values, timing constants and state encoding.
// Assumes a 10 MHz pclk and an APB master with 32-bit data.
package nfs_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ           = 10_000_000;
  localparam int unsigned HOLD_TICK_MS     = 10;
  localparam int unsigned HOLD_TICK_CYCLES = CLK_HZ / 1000 * HOLD_TICK_MS;

  // Hold time, in 10 ms ticks
  localparam int unsigned HOLD_W           = 11;
  localparam logic [HOLD_W-1:0] HOLD_MIN   = 11'h001;
  localparam logic [HOLD_W-1:0] HOLD_MAX   = 11'h7d0;
  localparam logic [HOLD_W-1:0] HOLD_RESET = 11'h00a;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_HOLD       = 8'h04;
  localparam logic [7:0] OFS_STATUS     = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] OFS_IRQ_CLEAR  = 8'h14;
  localparam logic [7:0] OFS_CFG_STAGE  = 8'h18;
  localparam logic [7:0] OFS_CFG_ACTIVE = 8'h1c;
  localparam logic [7:0] OFS_COMMAND    = 8'h20;

  // Control register fields
  localparam int unsigned CTRL_ACTION_LSB = 0;
  localparam int unsigned CTRL_LINKFN_LSB = 2;
  localparam int unsigned CTRL_WARN_BIT   = 4;
  localparam logic [4:0]  CTRL_RESET      = 5'h00;

  // Status register fields
  localparam int unsigned STAT_LIGHT_BIT  = 0;
  localparam int unsigned STAT_HEAVY_BIT  = 1;
  localparam int unsigned STAT_TRIP_BIT   = 2;
  localparam int unsigned STAT_WARN_BIT   = 3;
  localparam int unsigned STAT_HOLD_BIT   = 4;
  localparam int unsigned STAT_LINKOP_BIT = 5;
  localparam int unsigned STAT_SUB_LSB    = 8;

  // Interrupt bits
  localparam int unsigned IRQ_W         = 4;
  localparam int unsigned IRQ_TRIP_BIT  = 0;
  localparam int unsigned IRQ_LIGHT_BIT = 1;
  localparam int unsigned IRQ_RECOV_BIT = 2;
  localparam int unsigned IRQ_WARN_BIT  = 3;

  // Command register: bit 0 is a software reset command
  localparam int unsigned CMD_RESET_BIT = 0;

  // Link configuration staging
  localparam int unsigned CFG_W          = 16;
  localparam logic [CFG_W-1:0] CFG_RESET = 16'h0000;

  // Alarm subcodes
  localparam logic [7:0] SUB_NONE  = 8'h00;
  localparam logic [7:0] SUB_LIGHT = 8'h01;
  localparam logic [7:0] SUB_HEAVY = 8'h04;

  // Error action and link function codes
  localparam logic [1:0] ACT_TRIP_NOW  = 2'h0;
  localparam logic [1:0] ACT_HOLD_TRIP = 2'h1;
  localparam logic [1:0] ACT_HOLD_RECV = 2'h2;
  localparam logic [1:0] ACT_CONTINUE  = 2'h3;
  localparam logic [1:0] LINKFN_CMD    = 2'h2;
  localparam logic [1:0] LINKFN_ALL    = 2'h3;

  localparam int unsigned SPEED_W = 16;

  typedef enum logic [3:0] {
    NFS_NORMAL = 4'b0001,
    NFS_HOLD   = 4'b0010,
    NFS_RIDE   = 4'b0100,
    NFS_TRIP   = 4'b1000
  } nfs_state_e;

endpackage

// ===== rtl/nfs_supervisor.sv
// Network fault supervisor: classifies fieldbus link alarms, applies the
// selected error response, holds link commands and manages trip reset.
// Assumes alarm, enable and reset-key inputs are asynchronous pins, and the
// link command strobe comes from card logic on pclk.
// Function
// R1: Action 0 trips at once on light alarm
// R2: Action 1 rides through, trips at timeout
// R3: Action 1 follows recovered link, still trips
// R4: Action 2 trips only if alarm persists
// R5: Action 3 never trips on light alarm
// R6: Ride-through keeps last run and speed
// R7: Hold time 0.01-20.00 s, default 0.10 s
// R8: Hold time used only in actions 1,2
// R9: Master loss, break, data error are light
// R10: Card failure is heavy, trips at once
// R11: Light fault only while link operation enabled
// R12: Subcode records first cause, 01 or 04
// R13: Light clears on recovery or disable+reset
// R14: Heavy clears on cause removed plus reset
// R15: Reset from key, digital input, or link
// R16: Warning definition continues instead of tripping
// R17: Timer starts at onset, 10 ms ticks
// R18: Link configuration applied only when stopped
module nfs_supervisor
  import nfs_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = HOLD_TICK_CYCLES
) (
  // Clock, reset, enable
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               clk_en,
  // APB slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Alarm pins from the interface card
  input  wire logic               link_master_lost,
  input  wire logic               link_break,
  input  wire logic               link_data_error,
  input  wire logic               card_failure,
  input  wire logic               card_misinstalled,
  input  wire logic               link_enable_input,
  // Reset sources
  input  wire logic               reset_key,
  input  wire logic               reset_dinput,
  input  wire logic               link_reset_req,
  // Link commands
  input  wire logic               link_rx_valid,
  input  wire logic               link_run_cmd,
  input  wire logic [SPEED_W-1:0] link_speed_cmd,
  // Drive control
  output logic                    drive_run,
  output logic      [SPEED_W-1:0] drive_speed,
  output logic                    net_fault_trip,
  output logic                    net_fault_warning,
  output logic      [7:0]         fault_subcode,
  output logic      [CFG_W-1:0]   link_cfg_active,
  output logic                    irq
);

  localparam int unsigned PRE_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  if (TICK_CYCLES < 1) begin : g_chk
    $error("TICK_CYCLES must be at least 1");
  end

  function automatic logic in_hold_range(input logic [31:0] v);
    return (v >= 32'(HOLD_MIN)) && (v <= 32'(HOLD_MAX));
  endfunction

  // Registers
  logic [4:0]        ctrl_reg;
  logic [HOLD_W-1:0] hold_reg;
  logic [IRQ_W-1:0]  irq_status_reg;
  logic [IRQ_W-1:0]  irq_enable_reg;
  logic [CFG_W-1:0]  cfg_stage_reg;
  logic [CFG_W-1:0]  cfg_active_reg;
  logic              sw_reset_reg;

  // Synchronisers
  logic [5:0] pin_s1_reg;
  logic [5:0] pin_s2_reg;
  logic [1:0] rst_s1_reg;
  logic [1:0] rst_s2_reg;
  logic [1:0] rst_s3_reg;

  // Supervisor state
  nfs_state_e        state_reg;
  nfs_state_e        state_next;
  logic [PRE_W-1:0]  pre_reg;
  logic [HOLD_W-1:0] tick_cnt_reg;
  logic              recovered_reg;
  logic              warn_reg;
  logic              light_prev_reg;
  logic [7:0]        subcode_reg;
  logic              run_hold_reg;
  logic [SPEED_W-1:0] speed_hold_reg;

  logic [1:0] action;
  logic [1:0] link_fn;
  logic       warn_def;
  logic       light_now;
  logic       heavy_now;
  logic       link_op;
  logic       light_fault;
  logic       light_onset;
  logic       reset_cmd;
  logic       tick;
  logic       timer_done;
  logic       to_trip_light;
  logic       to_trip_heavy;
  logic       trip_clear;

  assign action   = ctrl_reg[CTRL_ACTION_LSB +: 2];
  assign link_fn  = ctrl_reg[CTRL_LINKFN_LSB +: 2];
  assign warn_def = ctrl_reg[CTRL_WARN_BIT];

  // Two-stage synchronisers for asynchronous pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_reg <= 6'h00;
      pin_s2_reg <= 6'h00;
      rst_s1_reg <= 2'h0;
      rst_s2_reg <= 2'h0;
      rst_s3_reg <= 2'h0;
    end else if (clk_en) begin
      pin_s1_reg <= {link_enable_input, card_misinstalled, card_failure,
                     link_data_error, link_break, link_master_lost};
      pin_s2_reg <= pin_s1_reg;
      rst_s1_reg <= {reset_dinput, reset_key};
      rst_s2_reg <= rst_s1_reg;
      rst_s3_reg <= rst_s2_reg;
    end
  end

  assign light_now   = |pin_s2_reg[2:0]; // R9
  assign heavy_now   = |pin_s2_reg[4:3]; // R10
  assign link_op     = ((link_fn == LINKFN_CMD) || (link_fn == LINKFN_ALL)) && pin_s2_reg[5]; // R11
  assign light_fault = light_now && link_op; // R11
  assign light_onset = light_fault && !light_prev_reg;
  // Rising edges of key and digital input, link request, or software command
  assign reset_cmd   = (|(rst_s2_reg & ~rst_s3_reg)) || link_reset_req || sw_reset_reg; // R15

  // 10 ms tick prescaler, restarted at alarm onset
  assign tick       = (pre_reg == PRE_W'(TICK_CYCLES - 1));
  assign timer_done = tick && (tick_cnt_reg >= hold_reg - HOLD_W'(1)); // R7

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg      <= '0;
      tick_cnt_reg <= '0;
    end else if (clk_en) begin
      if (light_onset || state_reg != NFS_HOLD) begin
        pre_reg      <= '0; // R17
        tick_cnt_reg <= '0; // R17
      end else if (tick) begin
        pre_reg      <= '0;
        tick_cnt_reg <= tick_cnt_reg + HOLD_W'(1); // R17
      end else begin
        pre_reg <= pre_reg + PRE_W'(1);
      end
    end
  end

  assign to_trip_heavy = heavy_now;

  // Next state
  always_comb begin
    state_next    = state_reg;
    to_trip_light = 1'b0;
    trip_clear    = 1'b0;
    case (state_reg)
      NFS_NORMAL: begin
        if (to_trip_heavy) begin
          state_next = NFS_TRIP; // R10
        end else if (light_onset) begin
          if (warn_def || action == ACT_CONTINUE) begin
            state_next = NFS_RIDE; // R5 R16
          end else if (action == ACT_TRIP_NOW) begin
            state_next    = NFS_TRIP; // R1
            to_trip_light = 1'b1;
          end else begin
            state_next = NFS_HOLD; // R8
          end
        end
      end
      NFS_HOLD: begin
        if (to_trip_heavy) begin
          state_next = NFS_TRIP; // R10
        end else if (!link_op) begin
          state_next = NFS_NORMAL;
        end else if (action == ACT_HOLD_RECV && !light_now) begin
          state_next = NFS_NORMAL; // R4
        end else if (timer_done) begin
          state_next    = NFS_TRIP; // R2 R4
          to_trip_light = 1'b1;
        end
      end
      NFS_RIDE: begin
        if (to_trip_heavy) begin
          state_next = NFS_TRIP; // R10
        end else if (!light_fault) begin
          state_next = NFS_NORMAL; // R5
        end
      end
      NFS_TRIP: begin
        if (subcode_reg == SUB_HEAVY) begin
          trip_clear = !heavy_now && reset_cmd; // R14
        end else begin
          trip_clear = !heavy_now && (!light_now || (!link_op && reset_cmd)); // R13
        end
        if (trip_clear) begin
          state_next = NFS_NORMAL;
        end
      end
      default: state_next = NFS_NORMAL;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= NFS_NORMAL;
      light_prev_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg      <= state_next;
      light_prev_reg <= light_fault;
    end
  end

  // Recovery within hold period in action 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recovered_reg <= 1'b0;
    end else if (clk_en) begin
      if (state_reg != NFS_HOLD || light_onset) begin
        recovered_reg <= 1'b0;
      end else if (!light_now) begin
        recovered_reg <= 1'b1; // R3
      end
    end
  end

  // Warning indication for continued running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      warn_reg <= 1'b0;
    end else if (clk_en) begin
      if (state_reg == NFS_NORMAL && light_onset && warn_def) begin
        warn_reg <= 1'b1; // R16
      end else if (state_next != NFS_RIDE) begin
        warn_reg <= 1'b0;
      end
    end
  end

  // Subcode of first cause, kept until trip clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subcode_reg <= SUB_NONE;
    end else if (clk_en) begin
      if (state_reg != NFS_TRIP && state_next == NFS_TRIP) begin
        subcode_reg <= to_trip_heavy ? SUB_HEAVY : SUB_LIGHT; // R12
      end else if (trip_clear) begin
        subcode_reg <= SUB_NONE;
      end
    end
  end

  // Commands are taken only while the link is healthy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_hold_reg   <= 1'b0;
      speed_hold_reg <= '0;
    end else if (clk_en) begin
      if (link_rx_valid && !light_now) begin
        run_hold_reg   <= link_run_cmd; // R3 R6
        speed_hold_reg <= link_speed_cmd; // R6
      end
    end
  end

  assign drive_run         = run_hold_reg && (state_reg != NFS_TRIP);
  assign drive_speed       = speed_hold_reg;
  assign net_fault_trip    = (state_reg == NFS_TRIP);
  assign net_fault_warning = warn_reg;
  assign fault_subcode     = subcode_reg;
  assign link_cfg_active   = cfg_active_reg;

  // APB access decode
  logic       wr_en;
  logic       rd_en;
  logic       addr_ok;
  logic [IRQ_W-1:0] irq_events;

  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && penable && !pwrite;

  always_comb begin
    if (paddr == OFS_CTRL || paddr == OFS_HOLD || paddr == OFS_STATUS) begin
      addr_ok = 1'b1;
    end else if (paddr == OFS_IRQ_STATUS || paddr == OFS_IRQ_ENABLE || paddr == OFS_IRQ_CLEAR) begin
      addr_ok = 1'b1;
    end else if (paddr == OFS_CFG_STAGE || paddr == OFS_CFG_ACTIVE || paddr == OFS_COMMAND) begin
      addr_ok = 1'b1;
    end else begin
      addr_ok = 1'b0;
    end
  end

  assign pslverr = psel && penable && !addr_ok;

  // Writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg       <= CTRL_RESET;
      hold_reg       <= HOLD_RESET;
      irq_enable_reg <= '0;
      cfg_stage_reg  <= CFG_RESET;
      sw_reset_reg   <= 1'b0;
    end else if (clk_en) begin
      sw_reset_reg <= 1'b0;
      if (wr_en && paddr == OFS_CTRL) begin
        ctrl_reg <= pwdata[4:0];
      end else if (wr_en && paddr == OFS_HOLD) begin
        if (in_hold_range(pwdata)) begin
          hold_reg <= pwdata[HOLD_W-1:0]; // R7
        end
      end else if (wr_en && paddr == OFS_IRQ_ENABLE) begin
        irq_enable_reg <= pwdata[IRQ_W-1:0];
      end else if (wr_en && paddr == OFS_CFG_STAGE) begin
        cfg_stage_reg <= pwdata[CFG_W-1:0];
      end else if (wr_en && paddr == OFS_COMMAND) begin
        sw_reset_reg <= pwdata[CMD_RESET_BIT]; // R15
      end
    end
  end

  // Staged configuration taken over only while the drive is stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_active_reg <= CFG_RESET;
    end else if (clk_en) begin
      if (!drive_run) begin
        cfg_active_reg <= cfg_stage_reg; // R18
      end
    end
  end

  // Sticky interrupt status; a new event wins over a clear
  assign irq_events[IRQ_TRIP_BIT]  = (state_reg != NFS_TRIP) && (state_next == NFS_TRIP);
  assign irq_events[IRQ_LIGHT_BIT] = light_onset;
  assign irq_events[IRQ_RECOV_BIT] = !light_fault && light_prev_reg;
  assign irq_events[IRQ_WARN_BIT]  = !warn_reg && (state_reg == NFS_NORMAL) && light_onset && warn_def;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= '0;
    end else if (clk_en) begin
      if (wr_en && paddr == OFS_IRQ_CLEAR) begin
        irq_status_reg <= (irq_status_reg & ~pwdata[IRQ_W-1:0]) | irq_events;
      end else begin
        irq_status_reg <= irq_status_reg | irq_events;
      end
    end
  end

  assign irq = |(irq_status_reg & irq_enable_reg);

  // Read data
  logic [31:0] status_word;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[STAT_LIGHT_BIT]          = light_now;
    status_word[STAT_HEAVY_BIT]          = heavy_now;
    status_word[STAT_TRIP_BIT]           = net_fault_trip;
    status_word[STAT_WARN_BIT]           = warn_reg;
    status_word[STAT_HOLD_BIT]           = (state_reg == NFS_HOLD);
    status_word[STAT_LINKOP_BIT]         = link_op;
    status_word[STAT_SUB_LSB +: 8]       = subcode_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (clk_en) begin
      if (psel && !penable && !pwrite) begin
        if (paddr == OFS_CTRL) begin
          prdata <= {27'h000_0000, ctrl_reg};
        end else if (paddr == OFS_HOLD) begin
          prdata <= {21'h00_0000, hold_reg};
        end else if (paddr == OFS_STATUS) begin
          prdata <= status_word;
        end else if (paddr == OFS_IRQ_STATUS) begin
          prdata <= {28'h000_0000, irq_status_reg};
        end else if (paddr == OFS_IRQ_ENABLE) begin
          prdata <= {28'h000_0000, irq_enable_reg};
        end else if (paddr == OFS_CFG_STAGE) begin
          prdata <= {16'h0000, cfg_stage_reg};
        end else if (paddr == OFS_CFG_ACTIVE) begin
          prdata <= {16'h0000, cfg_active_reg};
        end else begin
          prdata <= 32'h0000_0000;
        end
      end
    end
  end

  logic unused_rd;
  assign unused_rd = rd_en;

endmodule

// ===== tb/nfs_supervisor_properties.sv
// Port assertions for the network fault supervisor.
// Assumes clk_en held high; bound from the bench top file.
module nfs_supervisor_properties
  import nfs_pkg::*;
(
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // Bus
  input wire logic               psel,
  input wire logic               penable,
  input wire logic [7:0]         paddr,
  input wire logic               pready,
  input wire logic               pslverr,
  // Pins
  input wire logic               card_failure,
  input wire logic               card_misinstalled,
  input wire logic               link_master_lost,
  input wire logic               reset_key,
  input wire logic               reset_dinput,
  input wire logic               link_reset_req,
  // Drive side
  input wire logic               drive_run,
  input wire logic [SPEED_W-1:0] drive_speed,
  input wire logic               net_fault_trip,
  input wire logic [7:0]         fault_subcode,
  input wire logic [CFG_W-1:0]   link_cfg_active
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic heavy_pin;
  logic quiet;
  assign heavy_pin = card_failure || card_misinstalled;
  assign quiet     = !psel && !reset_key && !reset_dinput && !link_reset_req;
  bus_ready_a: assert property (pready)
    else $error("pready low");
  bus_decode_a: assert property (pslverr == (psel && penable && (paddr > OFS_COMMAND || paddr[1:0] != 2'h0)))
    else $error("pslverr does not match decode");
  coast_stop_a: assert property (net_fault_trip |-> !drive_run)
    else $error("run while tripped");
  heavy_trip_a: assert property (heavy_pin [*5] |-> net_fault_trip)
    else $error("no trip on card fault");
  first_cause_a: assert property ($rose(net_fault_trip) |->
    fault_subcode == ($past(heavy_pin, 2) ? SUB_HEAVY : SUB_LIGHT))
    else $error("wrong subcode at trip");
  ride_hold_a: assert property (link_master_lost [*5] |-> $stable(drive_speed))
    else $error("speed moved during link loss");
  heavy_latch_a: assert property ((net_fault_trip && fault_subcode == SUB_HEAVY && quiet) [*5]
    |=> net_fault_trip)
    else $error("heavy trip cleared without reset");
  cfg_freeze_a: assert property (drive_run |=> $stable(link_cfg_active))
    else $error("config changed while running");
endmodule

// ===== tb/nfs_link_master.sv
// Fieldbus master model seen through the card: periodic command frames.
// Assumes the bench sets online, run and speed off the clock edge.
module nfs_link_master
  import nfs_pkg::*;
(
  // Control from the bench
  input  wire logic               pclk,
  input  wire logic               online,
  input  wire logic               run,
  input  wire logic [SPEED_W-1:0] speed,
  // Card side
  output logic                    link_rx_valid,
  output logic                    link_run_cmd,
  output logic      [SPEED_W-1:0] link_speed_cmd,
  output logic                    link_master_lost
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] gap_reg;
  initial begin
    gap_reg          = 3'h0;
    link_rx_valid    = 1'h0;
    link_run_cmd     = 1'h0;
    link_speed_cmd   = 16'h0000;
    link_master_lost = 1'h1;
  end
  // Outside a frame the data lines toggle so stale values never look valid
  always @(posedge pclk) begin
    gap_reg          <= gap_reg + 3'h1;
    link_master_lost <= !online;
    link_rx_valid    <= online && gap_reg == 3'h0;
    if (online && gap_reg == 3'h0) begin
      link_run_cmd   <= run;
      link_speed_cmd <= speed;
    end else begin
      link_run_cmd   <= ~link_run_cmd;
      link_speed_cmd <= ~link_speed_cmd;
    end
  end
endmodule

// ===== tb/network_fault_supervisor_tb.sv
// Self-checking bench for the network fault supervisor.
// Assumes a 10-cycle hold tick and the link master model at the far side.
module network_fault_supervisor_tb;
  import nfs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic               pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic               irq, drive_run, net_fault_trip, net_fault_warning, rerr;
  logic               link_break, link_data_error, card_failure, card_misinstalled;
  logic               link_enable_input, reset_key, reset_dinput, link_reset_req;
  logic               link_rx_valid, link_run_cmd, link_master_lost, online, run;
  logic [7:0]         paddr, fault_subcode;
  logic [31:0]        pwdata, prdata, rdata;
  logic [SPEED_W-1:0] link_speed_cmd, drive_speed, speed;
  logic [CFG_W-1:0]   link_cfg_active;
  int                 fail_count, cmp_count, cycles;
  logic [1:0]         fn_tab [6] = '{2'h3, 2'h2, 2'h3, 2'h1, 2'h0, 2'h3};
  logic [31:0]        hold_try [4] = '{32'h0000_0000, 32'h0000_07d1, 32'h0000_07d0, 32'h0000_0001};
  logic [31:0]        hold_exp [4] = '{32'h0000_000a, 32'h0000_000a, 32'h0000_07d0, 32'h0000_0001};

  nfs_supervisor #(.TICK_CYCLES(10)) i_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .link_master_lost, .link_break, .link_data_error,
    .card_failure, .card_misinstalled, .link_enable_input, .reset_key, .reset_dinput,
    .link_reset_req, .link_rx_valid, .link_run_cmd, .link_speed_cmd, .drive_run, .drive_speed,
    .net_fault_trip, .net_fault_warning, .fault_subcode, .link_cfg_active, .irq);
  nfs_link_master i_master (.pclk, .online, .run, .speed, .link_rx_valid, .link_run_cmd,
    .link_speed_cmd, .link_master_lost);

  always #50 pclk = ~pclk;

  task automatic give_verdict();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("ERROR %0t: run too long", $time);
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic flag(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
    end
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    // Idle edge so the next call never re-raises psel in this time step
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0000_0000);
    check(rdata, exp);
  endtask
  task automatic rst_pulse(input int s);
    reset_key      <= s == 0;
    reset_dinput   <= s == 1;
    link_reset_req <= s == 2;
    tick(4);
    reset_key      <= 1'h0;
    reset_dinput   <= 1'h0;
    link_reset_req <= 1'h0;
    tick(6);
  endtask

  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {link_break, link_data_error, card_failure, card_misinstalled} = '0;
    {reset_key, reset_dinput, link_reset_req, fail_count, cmp_count, cycles} = '0;
    {clk_en, link_enable_input, online, run} = '1;
    speed = 16'h0000;
    tick(6);
    presetn <= 1'h1;
    tick(2);
    rd(OFS_CTRL, 32'h0000_0000);
    rd(OFS_STATUS, 32'h0000_0000);
    apb(1'h0, 8'h24, 32'h0000_0000);
    flag(rerr, 1'h1);
    foreach (hold_try[i]) begin
      apb(1'h1, OFS_HOLD, hold_try[i]);
      rd(OFS_HOLD, hold_exp[i]);
    end
    apb(1'h1, OFS_HOLD, 32'h0000_0003);
    for (int a = 0; a < 4; a++) begin
      speed <= 16'h1000 | 16'(a);
      apb(1'h1, OFS_CTRL, 32'h0000_000c | 32'(a));
      tick(20);
      flag(drive_run, 1'h1);
      online <= 1'h0;
      speed  <= 16'h2000 | 16'(a);
      tick(12);
      flag(net_fault_trip, a == 0);
      flag(drive_run, a != 0);
      check({16'h0000, drive_speed}, 32'h0000_1000 | 32'(a));
      tick(30);
      flag(net_fault_trip, a < 3);
      online <= 1'h1;
      tick(20);
      flag(net_fault_trip, 1'h0);
      check({16'h0000, drive_speed}, 32'h0000_2000 | 32'(a));
    end
    for (int a = 1; a < 3; a++) begin
      apb(1'h1, OFS_CTRL, 32'h0000_000c | 32'(a));
      apb(1'h1, OFS_IRQ_CLEAR, 32'h0000_000f);
      online <= 1'h0;
      tick(10);
      online <= 1'h1;
      speed  <= 16'h3000 | 16'(a);
      tick(16);
      check({16'h0000, drive_speed}, 32'h0000_3000 | 32'(a));
      tick(30);
      apb(1'h0, OFS_IRQ_STATUS, 32'h0000_0000);
      flag(rdata[IRQ_TRIP_BIT], a == 1);
    end
    for (int i = 0; i < 6; i++) begin
      apb(1'h1, OFS_CTRL, {28'h000_0000, fn_tab[i], 2'h0});
      link_enable_input <= i != 5;
      link_break        <= i == 1 || i > 2;
      link_data_error   <= i == 2;
      online            <= i != 0;
      tick(10);
      flag(net_fault_trip, i < 3);
      {online, link_enable_input} <= 2'h3;
      link_break      <= 1'h0;
      link_data_error <= 1'h0;
      tick(20);
      flag(net_fault_trip, 1'h0);
    end
    apb(1'h1, OFS_CTRL, 32'h0000_001c);
    link_break <= 1'h1;
    tick(10);
    flag(net_fault_warning, 1'h1);
    flag(drive_run, 1'h1);
    apb(1'h1, OFS_CTRL, 32'h0000_000c);
    link_break <= 1'h0;
    tick(6);
    link_break <= 1'h1;
    tick(6);
    flag(net_fault_trip, 1'h1);
    apb(1'h1, OFS_CTRL, 32'h0000_0000);
    apb(1'h1, OFS_COMMAND, 32'h0000_0001);
    tick(3);
    flag(net_fault_trip, 1'h0);
    link_break <= 1'h0;
    apb(1'h1, OFS_CTRL, 32'h0000_000f);
    apb(1'h1, OFS_IRQ_CLEAR, 32'h0000_000f);
    for (int s = 0; s < 3; s++) begin
      card_failure      <= s != 1;
      card_misinstalled <= s == 1;
      tick(6);
      flag(net_fault_trip, 1'h1);
      check({24'h00_0000, fault_subcode}, 32'h0000_0004);
      rst_pulse(s);
      flag(net_fault_trip, 1'h1);
      card_failure      <= 1'h0;
      card_misinstalled <= 1'h0;
      tick(8);
      flag(net_fault_trip, 1'h1);
      rst_pulse(s);
      flag(net_fault_trip, 1'h0);
    end
    flag(irq, 1'h0);
    apb(1'h1, OFS_IRQ_ENABLE, 32'h0000_0001);
    tick(1);
    flag(irq, 1'h1);
    apb(1'h1, OFS_IRQ_CLEAR, 32'h0000_0001);
    tick(1);
    flag(irq, 1'h0);
    tick(20);
    flag(drive_run, 1'h1);
    apb(1'h1, OFS_CFG_STAGE, 32'h0000_00a5);
    tick(3);
    check({16'h0000, link_cfg_active}, 32'h0000_0000);
    run <= 1'h0;
    tick(20);
    rd(OFS_CFG_ACTIVE, 32'h0000_00a5);
    give_verdict();
  end
endmodule

bind nfs_supervisor nfs_supervisor_properties i_chk (.pclk, .presetn, .psel, .penable, .paddr,
  .pready, .pslverr, .card_failure, .card_misinstalled, .link_master_lost, .reset_key,
  .reset_dinput, .link_reset_req, .drive_run, .drive_speed, .net_fault_trip, .fault_subcode,
  .link_cfg_active);
